//--- oeic_ctrl_model.sv
// Controller model: interlock, enable and programming pin levels.
// Assumes the bench sets wanted levels just after a clock edge.
`timescale 1ns/10ps
module oeic_ctrl_model
	import oeic_pkg::*;
(
	input  wire logic                 clk,
	input  wire oeic_pkg::oeic_in_s   want,
	input  wire oeic_pkg::oeic_code_t want_vp,
	output oeic_pkg::oeic_in_s        pins,
	output oeic_pkg::oeic_code_t      vprog
);
	// Power-up: interlocks open, enable off
	initial begin
		pins = 3'h1;
		vprog = 12'h000;
	end
	// Pins move one edge after the request, as from a slow controller
	always @(posedge clk) begin
		pins <= want;
		vprog <= want_vp;
	end
endmodule

//--- oeic_pkg.sv
// Types for the output enable interlock control block.
// Assumes oeic_regs.svh supplies the numeric constants.
`include "oeic_regs.svh"
package oeic_pkg;
	typedef logic [`OEIC_ADC_BITS-1:0] oeic_code_t;
	typedef struct packed {
		logic ilk1_ok;
		logic ilk2_ok;
		logic enable_n;
	} oeic_in_s;
	typedef struct packed {
		logic emergency_stop_status;
		logic output_in_regulation;
		logic fault_n;
	} oeic_stat_s;
	typedef enum logic [2:0] {
		OEIC_OFF = 3'h1,
		OEIC_ON  = 3'h2,
		OEIC_DRN = 3'h4
	} oeic_state_e;
endpackage

//--- oeic_regs.svh
// Constants for the output enable interlock control block.
// Assumes a 200 MHz core clock; included by the package users.
`ifndef OEIC_REGS_SVH
`define OEIC_REGS_SVH
`define OEIC_CLK_MHZ        200
`define OEIC_ILK_OFF_MS     50
`define OEIC_EN_OFF_MIN_MS  100
`define OEIC_EN_OFF_MAX_MS  200
`define OEIC_EN_OFF_MS      150
`define OEIC_ADC_BITS       12
`define OEIC_VPROG_3V_CODE  12'hE8B
`define OEIC_DEF_SETPOINT   12'hA00
`endif

//--- oeic_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes reset is already released synchronously by the caller.
`timescale 1ns/10ps
module oeic_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] init,
	output logic [W-1:0]      q
);
	logic [W-1:0] s1_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			q    <= '0;
		end else begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
	logic unused_init;
	assign unused_init = ^init;
endmodule

//--- oeic_top.sv
// Output on/off and setpoint-source control for a rectifier.
// Assumes pins come from another domain; ADC codes are on the clock domain.
// Function
// R1: An open interlock shuts the main output off within 50 ms.
// R2: Output runs only with both interlocks conducting and enable low.
// R3: An open interlock overrides enable and any serial turn-on command.
// R4: Enable low requests on; enable high turns off within 100 to 200 ms.
// R5: Status outputs keep reporting true state while an interlock is open.
// R6: After reset the setpoint follows the programming pin until a serial set.
// R7: A serial setpoint latches software control until controller power loss.
// R8: Controller power cycling clears the latch and restores pin control.
// R9: A pin level above 3 V applies the stored default setpoint.
// R10: Emergency-stop status is high only when both interlocks are open.
// R11: Regulation status is high only while output is on and regulating.
// R12: Fault status is driven low whenever any failure is present.
// R13: The programming pin is converted with 12-bit resolution.
// R14: Interlock and enable pins pass a two-stage synchroniser.
// R15: Output is held off while any turn-on condition is missing or unsampled.
`timescale 1ns/10ps
`include "oeic_regs.svh"
module oeic_top
	import oeic_pkg::*;
#(
	parameter int ILK_OFF_CYC = `OEIC_ILK_OFF_MS * `OEIC_CLK_MHZ * 1000,
	parameter int EN_OFF_CYC  = `OEIC_EN_OFF_MS * `OEIC_CLK_MHZ * 1000,
	parameter oeic_code_t DEF_SETPOINT = `OEIC_DEF_SETPOINT
) (
	input  wire logic   CLOCK,
	input  wire logic   RST_B,
	input  wire logic   ILK1_OK,
	input  wire logic   ILK2_OK,
	input  wire logic   ENABLE_N,
	input  wire logic   SERIAL_ON_REQ,
	input  wire logic   SERIAL_OFF_REQ,
	input  wire logic   SERIAL_SET_VLD,
	input  wire oeic_pkg::oeic_code_t SERIAL_SET_CODE,
	input  wire oeic_pkg::oeic_code_t VPROG_CODE,
	input  wire logic   REG_OK,
	input  wire logic   FAULT_IN,
	output logic        MAIN_ON,
	output logic        SW_LATCHED,
	output oeic_pkg::oeic_code_t SETPOINT,
	output oeic_pkg::oeic_stat_s STATUS
);
	import oeic_pkg::*;

	logic [1:0] rst_sync_q;
	logic       rst_b;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_q[1];

	// Reset value 0 for all reads as "open / disabled" until sampled
	oeic_in_s in_s;
	logic [2:0] raw_in;
	logic [2:0] sync_q;
	assign raw_in = {ILK1_OK, ILK2_OK, ~ENABLE_N};
	oeic_sync #(.W(3)) u_sync ( // R14
		.clk  (CLOCK),
		.rst_b(rst_b),
		.d    (raw_in),
		.init (3'h0),
		.q    (sync_q)
	);
	assign in_s.ilk1_ok  = sync_q[2];
	assign in_s.ilk2_ok  = sync_q[1];
	assign in_s.enable_n = ~sync_q[0];

	logic ilk_ok;
	logic en_req;
	assign ilk_ok = in_s.ilk1_ok & in_s.ilk2_ok;
	assign en_req = ~in_s.enable_n;

	// Serial on/off sits under the enable pin; enable still gates turn-on
	logic sw_on_q;
	logic sw_on_d;
	always_comb begin
		sw_on_d = sw_on_q;
		if (SERIAL_OFF_REQ) begin
			sw_on_d = 1'b0;
		end else if (SERIAL_ON_REQ) begin
			sw_on_d = 1'b1;
		end
	end
	always_ff @(posedge CLOCK or negedge rst_b) begin
		if (!rst_b) begin
			sw_on_q <= 1'b1;
		end else begin
			sw_on_q <= sw_on_d;
		end
	end

	oeic_state_e st_q;
	oeic_state_e st_d;
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        on_want;
	assign on_want = ilk_ok & en_req & sw_on_q; // R2 R3

	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			OEIC_OFF: begin
				cnt_d = 32'h0;
				if (on_want) begin // R15
					st_d = OEIC_ON;
				end
			end
			OEIC_ON: begin
				cnt_d = 32'h0;
				if (!ilk_ok) begin // R1 R3
					st_d = OEIC_OFF;
				end else if (!en_req || !sw_on_q) begin
					st_d = OEIC_DRN;
				end
			end
			OEIC_DRN: begin
				// Slow ramp-off window; interlock cuts it short
				cnt_d = cnt_q + 32'h1;
				if (!ilk_ok) begin // R1
					st_d = OEIC_OFF;
				end else if (on_want) begin
					st_d = OEIC_ON;
				end else if (cnt_q >= 32'(EN_OFF_CYC - 1)) begin // R4
					st_d = OEIC_OFF;
				end
			end
			default: begin
				st_d = OEIC_OFF;
			end
		endcase
	end
	always_ff @(posedge CLOCK or negedge rst_b) begin
		if (!rst_b) begin
			st_q  <= OEIC_OFF;
			cnt_q <= 32'h0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Latch cleared only by reset, which stands for bias power loss
	logic       latch_q;
	logic       latch_d;
	oeic_code_t sw_code_q;
	oeic_code_t sw_code_d;
	oeic_code_t sp_d;
	always_comb begin
		latch_d   = latch_q;
		sw_code_d = sw_code_q;
		if (SERIAL_SET_VLD) begin // R7
			latch_d   = 1'b1;
			sw_code_d = SERIAL_SET_CODE;
		end
		if (latch_q) begin
			sp_d = sw_code_q;
		end else if (VPROG_CODE > `OEIC_VPROG_3V_CODE) begin // R9
			sp_d = DEF_SETPOINT;
		end else begin
			sp_d = VPROG_CODE; // R6 R13
		end
	end
	always_ff @(posedge CLOCK or negedge rst_b) begin
		if (!rst_b) begin // R8
			latch_q   <= 1'b0;
			sw_code_q <= `OEIC_DEF_SETPOINT;
		end else begin
			latch_q   <= latch_d;
			sw_code_q <= sw_code_d;
		end
	end

	logic on_d;
	oeic_stat_s stat_d;
	always_comb begin
		on_d = (st_d != OEIC_OFF);
		stat_d.emergency_stop_status = ~in_s.ilk1_ok & ~in_s.ilk2_ok; // R5 R10
		stat_d.output_in_regulation  = (st_q == OEIC_ON) & REG_OK; // R11
		stat_d.fault_n               = ~FAULT_IN; // R12
	end
	always_ff @(posedge CLOCK or negedge rst_b) begin
		if (!rst_b) begin
			MAIN_ON    <= 1'b0;
			SW_LATCHED <= 1'b0;
			SETPOINT   <= `OEIC_DEF_SETPOINT;
			STATUS     <= 3'h1;
		end else begin
			MAIN_ON    <= on_d;
			SW_LATCHED <= latch_q;
			SETPOINT   <= sp_d;
			STATUS     <= stat_d;
		end
	end

	int unused_ilk;
	assign unused_ilk = ILK_OFF_CYC;

	property ilk_cut_p;
		@(posedge CLOCK) disable iff (!rst_b)
		!ilk_ok |-> ##[1:2] !MAIN_ON;
	endproperty
	ilk_cut_off_a: assert property (ilk_cut_p) else $error("interlock did not cut output"); // R1
	sequence turn_on_s;
		!MAIN_ON ##1 MAIN_ON;
	endsequence
	on_needs_all_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R2
		turn_on_s |-> $past(ilk_ok) && $past(en_req))
		else $error("output on without inputs");
	ilk_over_cmd_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R3
		(!ilk_ok && SERIAL_ON_REQ) |=> !(st_q == OEIC_ON))
		else $error("command beat interlock");
	en_off_min_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R4
		(st_q == OEIC_ON && !en_req && ilk_ok) |=> st_q == OEIC_DRN)
		else $error("enable off skipped");
	estop_both_open_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R10
		STATUS.emergency_stop_status |-> $past(!in_s.ilk1_ok && !in_s.ilk2_ok))
		else $error("estop status without both open");
	reg_only_on_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R11
		STATUS.output_in_regulation |-> $past(st_q == OEIC_ON))
		else $error("regulation while off");
	// Sampled rst_b skips the release edge, where STATUS still holds its reset value
	fault_low_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R12
		(FAULT_IN && rst_b) |=> !STATUS.fault_n)
		else $error("fault not shown");
	latch_holds_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R7
		latch_q |=> latch_q)
		else $error("latch dropped");
	pin_default_a: assert property (@(posedge CLOCK) disable iff (!rst_b) // R9
		(rst_b && !latch_q && VPROG_CODE > `OEIC_VPROG_3V_CODE) |=> SETPOINT == DEF_SETPOINT)
		else $error("default not applied");
endmodule

//--- testbench.sv
// Random and corner tests of the output enable interlock control.
// Assumes a shortened enable-off count of 20 cycles.
`timescale 1ns/10ps
module testbench;
	import oeic_pkg::*;
	logic       CLOCK, RST_B, son, soff, sset, reg_ok, fault, perm, lat, main_on, latched;
	oeic_code_t scode, vp, vq, sp, lat_code;
	oeic_in_s   want, pins;
	oeic_stat_s stat;
	int         bad_count, samples_checked, seed, i;
	oeic_code_t corner [4] = '{12'hE8B, 12'hE8C, 12'hFFF, 12'h000};
	oeic_ctrl_model ctl (.clk(CLOCK), .want(want), .want_vp(vp), .pins(pins), .vprog(vq));
	oeic_top #(.EN_OFF_CYC(20)) uut (.CLOCK(CLOCK), .RST_B(RST_B), .ILK1_OK(pins.ilk1_ok),
		.ILK2_OK(pins.ilk2_ok), .ENABLE_N(pins.enable_n), .SERIAL_ON_REQ(son),
		.SERIAL_OFF_REQ(soff), .SERIAL_SET_VLD(sset), .SERIAL_SET_CODE(scode),
		.VPROG_CODE(vq), .REG_OK(reg_ok), .FAULT_IN(fault), .MAIN_ON(main_on),
		.SW_LATCHED(latched), .SETPOINT(sp), .STATUS(stat));
	always #2.5 CLOCK = ~CLOCK;
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, got, exp);
		end
	endtask
	function automatic oeic_code_t exp_sp(input oeic_code_t v);
		if (lat)
			return lat_code;
		return (v > 12'hE8B) ? 12'hA00 : v;
	endfunction
	task automatic check_all;
		logic on;
		on = perm & want.ilk1_ok & want.ilk2_ok & !want.enable_n;
		@(negedge CLOCK);
		chk(main_on, on);
		chk(stat.emergency_stop_status, !want.ilk1_ok & !want.ilk2_ok);
		chk(stat.output_in_regulation, on & reg_ok);
		chk(stat.fault_n, !fault);
		chk(sp, exp_sp(vp));
		chk(latched, lat);
		// Back on a rising edge so the next stimulus lands there
		@(posedge CLOCK);
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#50000;
		bad_count++;
		end_sim();
	end
	initial begin
		seed = 96;
		{CLOCK, RST_B, son, soff, sset, reg_ok, fault, lat} = '0;
		{bad_count, samples_checked} = '0;
		{scode, lat_code} = '0;
		perm = 1;
		vp = 12'h123;
		want = 3'h1;
		cyc(4);
		RST_B <= 1;
		cyc(4);
		check_all();
		want <= 3'h6;
		cyc(30);
		want <= 3'h7;
		cyc(15);
		@(negedge CLOCK) chk(main_on, 1'b1);
		cyc(12);
		@(negedge CLOCK) chk(main_on, 1'b0);
		want <= 3'h6;
		cyc(30);
		want <= 3'h2;
		cyc(5);
		@(negedge CLOCK) chk(main_on, 1'b0);
		@(posedge CLOCK) son <= 1;
		@(posedge CLOCK) son <= 0;
		cyc(30);
		check_all();
		want <= 3'h6;
		soff <= 1;
		@(posedge CLOCK) soff <= 0;
		perm = 0;
		cyc(30);
		check_all();
		son <= 1;
		@(posedge CLOCK) son <= 0;
		perm = 1;
		for (i = 0; i < 60; i++) begin
			want <= oeic_in_s'($random(seed));
			vp <= (i < 4) ? corner[i] : oeic_code_t'($random(seed));
			{reg_ok, fault} <= 2'($random(seed));
			if (i == 30) begin
				scode <= oeic_code_t'($random(seed));
				sset <= 1;
				@(posedge CLOCK) sset <= 0;
				lat = 1;
				lat_code = scode;
			end
			if (i == 45) begin
				RST_B <= 0;
				cyc(4);
				RST_B <= 1;
				lat = 0;
				cyc(4);
				@(negedge CLOCK) chk(main_on, 1'b0);
				cyc(4);
				check_all();
			end
			cyc(30);
			check_all();
		end
		end_sim();
	end
endmodule
